//--- dv/tb_top.sv
/*
  Self-checking bench: Wishbone register tasks, pad models on both ports.
  Assumes ack comes within 20 cycles of a request.
*/
`timescale 1ns/10ps
module tb_top;
  reg         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  reg  [11:2] adr = 0;
  reg  [31:0] wdat = 0, r;
  reg  [3:0]  sel = 0;
  reg  [15:0] a_en = 16'h0020, a_val = 0;
  wire [31:0] rdat;
  wire        ack, pa_irq, pb_irq;
  wire [15:0] pa_lvl, pa_o, pa_oe_n, pa_pu, pa_wk;
  wire [5:0]  pb_lvl, pb_o, pb_oe_n, pb_pu, pb_wk;
  integer     n_fail = 0, n_checks = 0, qcnt = 0;
  tpg_gpio_top u_tpg_gpio_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_level_reg_i(pa_lvl),
    .port_a_level_reg_o(pa_o), .port_a_level_reg_oe_n_o(pa_oe_n), .pa_pull_en_o(pa_pu), .pa_wake_arm_o(pa_wk), .pa_irq_o(pa_irq),
    .port_b_pin_level_i(pb_lvl), .port_b_pin_level_o(pb_o), .port_b_pin_level_oe_n_o(pb_oe_n), .pb_pull_en_o(pb_pu), .pb_wake_arm_o(pb_wk),
    .pb_irq_o(pb_irq));
  tpg_pad_model #(.W(16)) u_tpg_pad_model (.pin_i(pa_o), .oe_n_i(pa_oe_n), .ext_en_i(a_en), .ext_val_i(a_val),
    .lvl_o(pa_lvl));
  tpg_pad_model #(.W(6)) u_tpg_pad_model_b (.pin_i(pb_o), .oe_n_i(pb_oe_n), .ext_en_i(6'h00), .ext_val_i(6'h00),
    .lvl_o(pb_lvl));
  always #20 clk_i = ~clk_i;
  // cycles that pin a3 is actively pulled high
  always @(posedge clk_i) if (!pa_oe_n[3] && pa_o[3]) qcnt <= qcnt + 1;
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task bus(input [11:0] a, input w, input [31:0] d);
    integer k;
    begin
      k = 0;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a[11:2]; wdat <= d; sel <= 4'hf;
      do begin @(posedge clk_i); k = k + 1; end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin n_fail = n_fail + 1; print_verdict; end
      r = rdat;
      cyc <= 0; stb <= 0; we <= 0;
    end
  endtask
  task rchk(input [11:0] a, input [31:0] e); begin bus(a, 1'b0, 0); chk(r, e); end endtask
  task idle(input integer n); repeat (n) @(posedge clk_i); endtask
  initial begin
    idle(20); rst_i <= 0;
    rchk(12'h000, 0); rchk(12'h018, 0); rchk(12'h01c, 0); rchk(12'h020, 0);
    rchk(12'h008, 32'hffff); rchk(12'h048, 32'h3f);
    bus(12'h07c, 1'b0, 0);
    $display("test reset done");
    bus(12'h000, 1'b1, 32'he4); idle(4);
    chk(pa_oe_n[3:0], 4'b1101); chk(pa_o[1], 1);
    bus(12'h024, 1'b1, 32'h1); idle(3); chk(pa_pu, 16'h0009);
    bus(12'h008, 1'b1, 0); idle(4);
    chk(pa_oe_n[3:0], 4'b0001); chk(pa_o[3:1], 0);
    rchk(12'h010, 32'hffd1);
    bus(12'h040, 1'b1, 32'hffffffff); rchk(12'h040, 32'hfff);
    bus(12'h048, 1'b1, 32'hffffffff); rchk(12'h048, 32'h3f); idle(4); rchk(12'h050, 32'h3f);
    bus(12'h854, 1'b1, 0); rchk(12'h048, 32'h1f); idle(2); chk(pb_oe_n[5], 0);
    chk(pb_o, 6'h1f); chk(pb_pu, 6'h3f);
    bus(12'h804, 1'b1, 1); rchk(12'h008, 32'h2);
    rchk(12'h814, 0); rchk(12'h83c, 1);
    bus(12'h80c, 1'b1, 1); idle(12); chk(qcnt, 2); chk(pa_oe_n[3], 1);
    $display("test pins done");
    bus(12'h01c, 1'b1, 32'h200000); idle(3); chk(pa_wk, 16'h20);
    a_val <= 16'h20; idle(6); rchk(12'h020, 32'h20); chk(pa_irq, 1);
    bus(12'h020, 1'b1, 0); rchk(12'h020, 32'h20);
    bus(12'h020, 1'b1, 32'h20); idle(3); rchk(12'h020, 0); chk(pa_irq, 0);
    bus(12'h01c, 1'b1, 32'h20); a_val <= 0; idle(6); rchk(12'h020, 32'h20);
    bus(12'h018, 1'b1, 32'h20); bus(12'h01c, 1'b1, 32'h200020); bus(12'h020, 1'b1, 32'h20);
    idle(6); rchk(12'h020, 0);
    bus(12'h01c, 1'b1, 32'h20); idle(4); bus(12'h020, 1'b1, 32'h20); idle(4); rchk(12'h020, 32'h20);
    bus(12'h01c, 1'b1, 0); bus(12'h020, 1'b1, 32'h20); idle(4); rchk(12'h020, 0); chk(pa_wk, 0);
    bus(12'h058, 1'b1, 32'h20); bus(12'h05c, 1'b1, 32'h20); idle(6);
    chk(pb_irq, 1); chk(pb_wk, 6'h20);
    bus(12'h05c, 1'b1, 0); bus(12'h060, 1'b1, 32'h20); idle(4); chk(pb_irq, 0);
    $display("test irq done");
    print_verdict;
  end
endmodule // tb_top

//--- dv/tpg_gpio_chk.sv
/*
  Assertions on the ports of the gpio top.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module tpg_gpio_chk (
  input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pa_irq_o, pb_irq_o,
  input wire [11:2] wb_adr_i,
  input wire [15:0] port_a_level_reg_oe_n_o, pa_wake_arm_o,
  input wire [5:0]  port_b_pin_level_oe_n_o, pb_wake_arm_o
);
  // accepted writes to flag and enable words
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire ca = wr & (wb_adr_i == 10'h008);
  wire cb = wr & (wb_adr_i == 10'h018);
  wire ea = wr & (wb_adr_i == 10'h007);
  wire eb = wr & (wb_adr_i == 10'h017);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request drops at the edge that raises ack for its clear, or soon after
  sequence s_ca; ca || $past(ca) || $past(ca, 2); endsequence
  sequence s_cb; cb || $past(cb) || $past(cb, 2); endsequence
  sequence s_ea; $past(ea) || $past(ea, 2) || $past(ea, 3); endsequence
  sequence s_eb; $past(eb) || $past(eb, 2) || $past(eb, 3); endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack outside cycle");
  a_reset_pads_off: assert property ($fell(rst_i) |-> &port_a_level_reg_oe_n_o && &port_b_pin_level_oe_n_o)
    else $error("pads driven after reset");
  a_reset_irq_low: assert property ($fell(rst_i) |-> !pa_irq_o && !pb_irq_o)
    else $error("request after reset");
  a_reset_wake_off: assert property ($fell(rst_i) |-> pa_wake_arm_o == 0 && pb_wake_arm_o == 0)
    else $error("wake armed after reset");
  a_pa_irq_clear: assert property ($fell(pa_irq_o) |-> s_ca) else $error("port a request dropped");
  a_pb_irq_clear: assert property ($fell(pb_irq_o) |-> s_cb) else $error("port b request dropped");
  a_pa_wake_write: assert property ($changed(pa_wake_arm_o) |-> s_ea) else $error("port a wake moved");
  a_pb_wake_write: assert property ($changed(pb_wake_arm_o) |-> s_eb) else $error("port b wake moved");
endmodule // tpg_gpio_chk

bind tpg_gpio_top tpg_gpio_chk u_tpg_gpio_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .pa_irq_o(pa_irq_o), .pb_irq_o(pb_irq_o),
  .wb_adr_i(wb_adr_i), .port_a_level_reg_oe_n_o(port_a_level_reg_oe_n_o), .pa_wake_arm_o(pa_wake_arm_o),
  .port_b_pin_level_oe_n_o(port_b_pin_level_oe_n_o), .pb_wake_arm_o(pb_wake_arm_o));

//--- dv/tpg_pad_model.sv
/*
  Pad and board model for one port: resolves each pin from the block's drive
  and an external driver. Assumes a board pull-up on every pin, so a released
  pin with no external driver reads high.
*/
`timescale 1ns/10ps
module tpg_pad_model #(
  parameter W = 16
) (
  input  wire [W-1:0] pin_i,
  input  wire [W-1:0] oe_n_i,
  input  wire [W-1:0] ext_en_i,
  input  wire [W-1:0] ext_val_i,
  output wire [W-1:0] lvl_o
);
  // block drive wins; released lines follow the external driver or float up
  assign lvl_o = (~oe_n_i & pin_i) | (oe_n_i & ext_en_i & ext_val_i) | (oe_n_i & ~ext_en_i);
endmodule // tpg_pad_model

//--- src/tpg_gpio_defs.vh
/*
  Constants of the two-port GPIO block: register byte offsets, reset values,
  pin counts, mode encodings and the quasi-bidirectional drive-high time.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef TPG_GPIO_DEFS_VH
`define TPG_GPIO_DEFS_VH

// pins per port
`define TPG_PA_PINS          16
`define TPG_PB_PINS          6

// port a register byte offsets
`define TPG_PORT_A_PIN_MODE_CTRL_OFS      12'h000
`define TPG_PORT_A_OUTPUT_VALUE_OFS      12'h008
`define TPG_PA_LEVEL_OFS     12'h010
`define TPG_PA_KIND_OFS      12'h018
`define TPG_PA_IRQ_EN_OFS    12'h01c
`define TPG_PA_FLAGS_OFS     12'h020
`define TPG_PA_PULLUP_OFS    12'h024

// port b register byte offsets
`define TPG_PORT_B_PIN_MODE_CTRL_OFS      12'h040
`define TPG_PORT_B_OUTPUT_VALUE_OFS      12'h048
`define TPG_PB_LEVEL_OFS     12'h050
`define TPG_PB_KIND_OFS      12'h058
`define TPG_PB_IRQ_EN_OFS    12'h05c
`define TPG_PB_FLAGS_OFS     12'h060
`define TPG_PB_PULLUP_OFS    12'h064

// single-bit alias areas, one word per pin
`define TPG_PA_ALIAS_OFS     12'h800
`define TPG_PB_ALIAS_OFS     12'h840
`define TPG_ALIAS_AREA_MASK  12'hfc0

// field positions
`define TPG_RH_EN_LSB        16

// reset values
`define TPG_PORT_A_OUTPUT_VALUE_RST      16'hffff
`define TPG_PORT_B_OUTPUT_VALUE_RST      6'h3f

// pin mode field encodings
`define TPG_MODE_INPUT       2'h0
`define TPG_MODE_PUSH_PULL   2'h1
`define TPG_MODE_OPEN_DRAIN  2'h2
`define TPG_MODE_QUASI       2'h3

// quasi mode active drive-high time, in clock cycles
`define TPG_QUASI_HI_CYC     2'h2

`endif

//--- src/tpg_gpio_top.v
/*
  Two-port GPIO block: port a with 16 pins, port b with 6 pins, mode and
  output registers, pin level readback, per-pin edge or level interrupts,
  wake-up arming and single-bit alias registers behind a classic Wishbone
  slave. Assumes pads outside resolve the enables and pull-ups, and that the
  interrupt controller and power manager consume the request and wake lines.
*/
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
`include "tpg_gpio_defs.vh"

// Overview of operation
// - two-bit field picks input, push-pull, open-drain, quasi
// - port b bits above pin 5 read zero
// - output bit sets driven level in driving modes
// - output registers reset to all ones
// - level register returns present pin levels
// - trigger bit picks edge or level detection
// - level mode with both enables gives nothing
// - rise or high enable at bit n+16
// - fall or low enable at bit n
// - any enable also arms pin wake-up
// - level mode interrupts while level matches enable
// - edge mode interrupts on enabled transitions
// - flags stick; writing one clears them
// - alias write copies bit 0 to output bit
// - alias read returns pin level in bit 0
// - alias writes ignore any output data mask
// - aliases for a0-a15 and b0-b5, word spaced
// - open-drain drives low, releases on one
// - quasi one drives a low pin high two cycles, then releases
// - input mode driver off, optional pull-up
module tpg_gpio_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:2] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // port a pads
  input  wire [15:0] port_a_level_reg_i,
  output wire [15:0] port_a_level_reg_o,
  output wire [15:0] port_a_level_reg_oe_n_o,
  output wire [15:0] pa_pull_en_o,
  output reg  [15:0] pa_wake_arm_o,
  output wire        pa_irq_o,
  // port b pads
  input  wire [5:0]  port_b_pin_level_i,
  output wire [5:0]  port_b_pin_level_o,
  output wire [5:0]  port_b_pin_level_oe_n_o,
  output wire [5:0]  pb_pull_en_o,
  output reg  [5:0]  pb_wake_arm_o,
  output wire        pb_irq_o
);

  localparam PA_W = `TPG_PA_PINS;
  localparam PB_W = `TPG_PB_PINS;

  // port a configuration
  reg  [2*PA_W-1:0] port_a_pin_mode_ctrl;
  reg  [PA_W-1:0]   port_a_output_value;
  reg  [PA_W-1:0]   pa_kind;
  reg  [PA_W-1:0]   pa_rh_en;
  reg  [PA_W-1:0]   pa_fl_en;
  reg  [PA_W-1:0]   pa_pull;
  // port b configuration
  reg  [2*PB_W-1:0] port_b_pin_mode_ctrl;
  reg  [PB_W-1:0]   port_b_output_value;
  reg  [PB_W-1:0]   pb_kind;
  reg  [PB_W-1:0]   pb_rh_en;
  reg  [PB_W-1:0]   pb_fl_en;
  reg  [PB_W-1:0]   pb_pull;
  // status from the detectors
  wire [PA_W-1:0]   pa_lvl;
  wire [PA_W-1:0]   pa_flags;
  wire [PB_W-1:0]   pb_lvl;
  wire [PB_W-1:0]   pb_flags;

  // bus decode: one access per request, ack drops the cycle after
  wire        take     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr       = take & wb_we_i;
  wire [11:0] byte_adr = {wb_adr_i, 2'b00};
  wire [3:0]  pin_idx  = wb_adr_i[5:2];
  wire        pa_alias = (byte_adr & `TPG_ALIAS_AREA_MASK) == `TPG_PA_ALIAS_OFS;
  wire        pb_alias = ((byte_adr & `TPG_ALIAS_AREA_MASK) == `TPG_PB_ALIAS_OFS) &&
                         ({28'h0, pin_idx} < PB_W);
  wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wbits    = wb_dat_i & wmask;
  wire        alias_wr = wr & wb_sel_i[0];

  // write-one-to-clear strobes into the flag logic
  wire [PA_W-1:0] pa_clr = (wr && byte_adr == `TPG_PA_FLAGS_OFS) ? wbits[PA_W-1:0] :
                           {PA_W{1'b0}};
  wire [PB_W-1:0] pb_clr = (wr && byte_adr == `TPG_PB_FLAGS_OFS) ? wbits[PB_W-1:0] :
                           {PB_W{1'b0}};

  // byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  // merged write values: each register keeps the lanes not selected and
  // takes only the bits it implements, so reserved bits never get stored
  wire [31:0] port_a_pin_mode_ctrl_m = merge(port_a_pin_mode_ctrl, wb_dat_i, wmask);
  wire [31:0] port_a_output_value_m = merge({16'h0, port_a_output_value}, wb_dat_i, wmask);
  wire [31:0] pa_kind_m = merge({16'h0, pa_kind}, wb_dat_i, wmask);
  wire [31:0] pa_en_m   = merge({pa_rh_en, pa_fl_en}, wb_dat_i, wmask);
  wire [31:0] pa_pull_m = merge({16'h0, pa_pull}, wb_dat_i, wmask);
  wire [31:0] port_b_pin_mode_ctrl_m = merge({20'h0, port_b_pin_mode_ctrl}, wb_dat_i, wmask);
  wire [31:0] port_b_output_value_m = merge({26'h0, port_b_output_value}, wb_dat_i, wmask);
  wire [31:0] pb_kind_m = merge({26'h0, pb_kind}, wb_dat_i, wmask);
  wire [31:0] pb_en_m   = merge({10'h0, pb_rh_en, 10'h0, pb_fl_en}, wb_dat_i, wmask);
  wire [31:0] pb_pull_m = merge({26'h0, pb_pull}, wb_dat_i, wmask);

  // port a register writes; an alias word moves one output bit only
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_a_pin_mode_ctrl  <= {2*PA_W{1'b0}};
      port_a_output_value  <= `TPG_PORT_A_OUTPUT_VALUE_RST;
      pa_kind  <= {PA_W{1'b0}};
      pa_rh_en <= {PA_W{1'b0}};
      pa_fl_en <= {PA_W{1'b0}};
      pa_pull  <= {PA_W{1'b0}};
    end else if (wr) begin
      case (byte_adr)
        `TPG_PORT_A_PIN_MODE_CTRL_OFS: begin
          port_a_pin_mode_ctrl <= port_a_pin_mode_ctrl_m;
        end
        `TPG_PORT_A_OUTPUT_VALUE_OFS: begin
          port_a_output_value <= port_a_output_value_m[PA_W-1:0];
        end
        `TPG_PA_KIND_OFS: begin
          pa_kind <= pa_kind_m[PA_W-1:0];
        end
        `TPG_PA_IRQ_EN_OFS: begin
          pa_rh_en <= pa_en_m[`TPG_RH_EN_LSB+PA_W-1:`TPG_RH_EN_LSB];
          pa_fl_en <= pa_en_m[PA_W-1:0];
        end
        `TPG_PA_PULLUP_OFS: begin
          pa_pull <= pa_pull_m[PA_W-1:0];
        end
        default: begin
          // no output data mask exists, so the written bit lands whenever byte lane 0 is selected
          if (pa_alias && alias_wr)
            port_a_output_value[pin_idx] <= wb_dat_i[0];
        end
      endcase
    end
  end

  // port b register writes; only six pins exist, upper bits are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_b_pin_mode_ctrl  <= {2*PB_W{1'b0}};
      port_b_output_value  <= `TPG_PORT_B_OUTPUT_VALUE_RST;
      pb_kind  <= {PB_W{1'b0}};
      pb_rh_en <= {PB_W{1'b0}};
      pb_fl_en <= {PB_W{1'b0}};
      pb_pull  <= {PB_W{1'b0}};
    end else if (wr) begin
      case (byte_adr)
        `TPG_PORT_B_PIN_MODE_CTRL_OFS: begin
          port_b_pin_mode_ctrl <= port_b_pin_mode_ctrl_m[2*PB_W-1:0];
        end
        `TPG_PORT_B_OUTPUT_VALUE_OFS: begin
          port_b_output_value <= port_b_output_value_m[PB_W-1:0];
        end
        `TPG_PB_KIND_OFS: begin
          pb_kind <= pb_kind_m[PB_W-1:0];
        end
        `TPG_PB_IRQ_EN_OFS: begin
          pb_rh_en <= pb_en_m[`TPG_RH_EN_LSB+PB_W-1:`TPG_RH_EN_LSB];
          pb_fl_en <= pb_en_m[PB_W-1:0];
        end
        `TPG_PB_PULLUP_OFS: begin
          pb_pull <= pb_pull_m[PB_W-1:0];
        end
        default: begin
          if (pb_alias && alias_wr)
            port_b_output_value[pin_idx[2:0]] <= wb_dat_i[0];
        end
      endcase
    end
  end

  // wake-up arming follows either enable of a pin; the power manager
  // needs no interrupt flag to wake, only the armed mask
  always @(posedge clk_i) begin
    if (rst_i) begin
      pa_wake_arm_o <= {PA_W{1'b0}};
      pb_wake_arm_o <= {PB_W{1'b0}};
    end else begin
      pa_wake_arm_o <= pa_rh_en | pa_fl_en;
      pb_wake_arm_o <= pb_rh_en | pb_fl_en;
    end
  end

  // read value of the addressed word; reserved and unmapped bits read zero,
  // and the level words show the synchronised copy of each pin
  reg  [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0;
    case (byte_adr)
      `TPG_PORT_A_PIN_MODE_CTRL_OFS: begin
        next_rdata = port_a_pin_mode_ctrl;
      end
      `TPG_PORT_A_OUTPUT_VALUE_OFS: begin
        next_rdata = {16'h0, port_a_output_value};
      end
      `TPG_PA_LEVEL_OFS: begin
        next_rdata = {16'h0, pa_lvl};
      end
      `TPG_PA_KIND_OFS: begin
        next_rdata = {16'h0, pa_kind};
      end
      `TPG_PA_IRQ_EN_OFS: begin
        next_rdata = {pa_rh_en, pa_fl_en};
      end
      `TPG_PA_FLAGS_OFS: begin
        next_rdata = {16'h0, pa_flags};
      end
      `TPG_PA_PULLUP_OFS: begin
        next_rdata = {16'h0, pa_pull};
      end
      `TPG_PORT_B_PIN_MODE_CTRL_OFS: begin
        next_rdata = {20'h0, port_b_pin_mode_ctrl};
      end
      `TPG_PORT_B_OUTPUT_VALUE_OFS: begin
        next_rdata = {26'h0, port_b_output_value};
      end
      `TPG_PB_LEVEL_OFS: begin
        next_rdata = {26'h0, pb_lvl};
      end
      `TPG_PB_KIND_OFS: begin
        next_rdata = {26'h0, pb_kind};
      end
      `TPG_PB_IRQ_EN_OFS: begin
        next_rdata = {10'h0, pb_rh_en, 10'h0, pb_fl_en};
      end
      `TPG_PB_FLAGS_OFS: begin
        next_rdata = {26'h0, pb_flags};
      end
      `TPG_PB_PULLUP_OFS: begin
        next_rdata = {26'h0, pb_pull};
      end
      default: begin
        if (pa_alias)
          next_rdata = {31'h0, pa_lvl[pin_idx]};
        else if (pb_alias)
          next_rdata = {31'h0, pb_lvl[pin_idx[2:0]]};
      end
    endcase
  end

  // ack one clock after the request; a request seen with ack high is not
  // taken again, so a master that holds its strobe gets one access every two clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  // read data is loaded with the ack and holds until the next read is taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (take && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // pad stages; the level fed back is the synchronised copy, so a quasi pin
  // judges its start level two clocks late, which the hold flag tolerates
  tpg_pin_drv #(
    .W (PA_W)
  ) u_tpg_pin_drv_a (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .mode_i     (port_a_pin_mode_ctrl),
    .dout_i     (port_a_output_value),
    .pull_i     (pa_pull),
    .lvl_i      (pa_lvl),
    .pin_o      (port_a_level_reg_o),
    .pin_oe_n_o (port_a_level_reg_oe_n_o),
    .pull_en_o  (pa_pull_en_o)
  );

  tpg_pin_drv #(
    .W (PB_W)
  ) u_tpg_pin_drv_b (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .mode_i     (port_b_pin_mode_ctrl),
    .dout_i     (port_b_output_value),
    .pull_i     (pb_pull),
    .lvl_i      (pb_lvl),
    .pin_o      (port_b_pin_level_o),
    .pin_oe_n_o (port_b_pin_level_oe_n_o),
    .pull_en_o  (pb_pull_en_o)
  );

  // interrupt detection per port; each also supplies the pin levels that
  // the level words, the alias reads and the quasi stages use
  tpg_irq_det #(
    .W (PA_W)
  ) u_tpg_irq_det_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (port_a_level_reg_i),
    .kind_i  (pa_kind),
    .rh_en_i (pa_rh_en),
    .fl_en_i (pa_fl_en),
    .clr_i   (pa_clr),
    .lvl_o   (pa_lvl),
    .flags_o (pa_flags),
    .irq_o   (pa_irq_o)
  );

  tpg_irq_det #(
    .W (PB_W)
  ) u_tpg_irq_det_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (port_b_pin_level_i),
    .kind_i  (pb_kind),
    .rh_en_i (pb_rh_en),
    .fl_en_i (pb_fl_en),
    .clr_i   (pb_clr),
    .lvl_o   (pb_lvl),
    .flags_o (pb_flags),
    .irq_o   (pb_irq_o)
  );

endmodule // tpg_gpio_top

//--- src/tpg_irq_det.v
/*
  Interrupt detection for one port: synchronises the pins, detects edges or
  levels per pin, keeps sticky source flags with write-one-to-clear, and
  raises one request while any flag is set. Assumes one clock for all inputs.
*/
`timescale 1ns/10ps
`include "tpg_gpio_defs.vh"

module tpg_irq_det #(
  parameter W = 16
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // raw pins and configuration
  input  wire [W-1:0] pin_i,
  input  wire [W-1:0] kind_i,
  input  wire [W-1:0] rh_en_i,
  input  wire [W-1:0] fl_en_i,
  input  wire [W-1:0] clr_i,
  // status
  output reg  [W-1:0] lvl_o,
  output reg  [W-1:0] flags_o,
  output reg          irq_o
);

  reg  [W-1:0] sync1;
  reg  [W-1:0] prev;
  reg  [1:0]   warm;
  wire         armed = (warm == 2'h3);
  // both level enables together cancel each other in level mode
  wire [W-1:0] lvl_set  = kind_i & ((rh_en_i & ~fl_en_i & lvl_o) |
                                    (fl_en_i & ~rh_en_i & ~lvl_o));
  wire [W-1:0] edge_set = ~kind_i & ((rh_en_i & lvl_o & ~prev) |
                                     (fl_en_i & ~lvl_o & prev));
  wire [W-1:0] set      = armed ? (lvl_set | edge_set) : {W{1'b0}};
  // set wins over a clear arriving in the same cycle
  wire [W-1:0] next_flags = (flags_o & ~clr_i) | set;

  // synchroniser, edge history and sticky flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1   <= {W{1'b0}};
      lvl_o   <= {W{1'b0}};
      prev    <= {W{1'b0}};
      warm    <= 2'h0;
      flags_o <= {W{1'b0}};
      irq_o   <= 1'b0;
    end else begin
      sync1   <= pin_i;
      lvl_o   <= sync1;
      prev    <= lvl_o;
      if (!armed)
        warm <= warm + 2'h1;  // no false edge while history fills
      flags_o <= next_flags;
      irq_o   <= |next_flags;
    end
  end

endmodule // tpg_irq_det

//--- src/tpg_pin_drv.v
/*
  Per-pin output stage for one port: turns the mode field and output bit of
  each pin into a registered pad level, active-low output enable and pull-up
  enable. Assumes the pad sums enables and pull-ups outside this block.
*/
`timescale 1ns/10ps
`include "tpg_gpio_defs.vh"

module tpg_pin_drv #(
  parameter W = 16
) (
  // clock and reset
  input  wire           clk_i,
  input  wire           rst_i,
  // configuration and pin level
  input  wire [2*W-1:0] mode_i,
  input  wire [W-1:0]   dout_i,
  input  wire [W-1:0]   pull_i,
  input  wire [W-1:0]   lvl_i,
  // pad controls
  output wire [W-1:0]   pin_o,
  output wire [W-1:0]   pin_oe_n_o,
  output wire [W-1:0]   pull_en_o
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_pin
      reg  [1:0] hi_cnt;
      reg        q_hold;
      reg        o_q;
      reg        oe_n_q;
      reg        pu_q;
      wire [1:0] m       = mode_i[2*i+1:2*i];
      wire       q_one   = (m == `TPG_MODE_QUASI) & dout_i[i];
      // a low pin seen when quasi-one begins gets a short push high
      wire       q_start = q_one & ~q_hold & ~lvl_i[i];
      wire       q_hi    = q_start | (hi_cnt != 2'h0);

      assign pin_o[i]      = o_q;
      assign pin_oe_n_o[i] = oe_n_q;
      assign pull_en_o[i]  = pu_q;

      // registered pad drive, driver off out of reset
      always @(posedge clk_i) begin
        if (rst_i) begin
          hi_cnt <= 2'h0;
          q_hold <= 1'b0;
          o_q    <= 1'b0;
          oe_n_q <= 1'b1;
          pu_q   <= 1'b0;
        end else begin
          q_hold <= q_one;
          if (!q_one)
            hi_cnt <= 2'h0;
          else if (q_start)
            hi_cnt <= `TPG_QUASI_HI_CYC - 2'h1;
          else if (hi_cnt != 2'h0)
            hi_cnt <= hi_cnt - 2'h1;
          case (m)
            `TPG_MODE_PUSH_PULL: begin
              o_q    <= dout_i[i];
              oe_n_q <= 1'b0;
              pu_q   <= 1'b0;
            end
            `TPG_MODE_OPEN_DRAIN: begin
              o_q    <= 1'b0;
              oe_n_q <= dout_i[i];
              pu_q   <= 1'b0;
            end
            `TPG_MODE_QUASI: begin
              o_q    <= dout_i[i];
              oe_n_q <= dout_i[i] & ~q_hi;
              pu_q   <= 1'b1;
            end
            default: begin
              o_q    <= 1'b0;
              oe_n_q <= 1'b1;
              pu_q   <= pull_i[i];
            end
          endcase
        end
      end
    end
  endgenerate

endmodule // tpg_pin_drv
